// file: rtl/rcis_pkg.sv
package rcis_pkg;

  // register indices; byte address is four times the index
  localparam int unsigned CTRL_A_IDX = 8'h01;
  localparam int unsigned CTRL_D_IDX = 8'h04;
  localparam int unsigned RATIO_IDX  = 8'h18;

  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_D_RESET = 8'h00;

  // receiver_control_a fields
  localparam int unsigned CA_SWITCH_BIT = 7;
  localparam int unsigned CA_RATE_BIT   = 1;

  // receiver_control_d fields
  localparam int unsigned CD_TRISTATE_BIT = 7;
  localparam int unsigned CD_MASTER_BIT   = 6;
  localparam int unsigned CD_RX_SEL_LSB   = 3;
  localparam int unsigned CD_PASS_SEL_LSB = 0;
  localparam int unsigned SEL_W           = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // framing: 256 source ticks per stereo sample, 64 bit clocks per sample
  localparam int unsigned WORD_CNT_W  = 7;
  localparam logic [6:0]  WORD_LAST   = 7'h7F;
  localparam logic        BIT_LAST    = 1'h1;
  // ratio window of 64 recovered ticks gives a 2.6 fixed-point ratio
  localparam int unsigned RATIO_WIN_W = 6;
  localparam logic [5:0]  RATIO_LAST  = 6'h3F;
  localparam logic [7:0]  COUNT_MAX   = 8'hFF;

  typedef struct packed {
    logic                   lowPower;
    logic                   refPrev;
    logic                   recPrev;
    logic                   switched;
    logic                   divPhase;
    logic                   mclk;
    logic                   mclkOe;
    logic                   bitClk;
    logic                   bitOe;
    logic                   bitCnt;
    logic                   wordClk;
    logic                   wordOe;
    logic [WORD_CNT_W-1:0]  wordCnt;
    logic [7:0]             refCount;
    logic [RATIO_WIN_W-1:0] winCnt;
    logic [7:0]             ratio;
    logic                   rxLine;
    logic                   passLine;
  } rcis_core_t;

  localparam rcis_core_t CORE_RESET = '{lowPower: 1'b1, default: '0};

endpackage

// file: rtl/rcis_reg_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rcis_reg_if;
  logic [7:0] ctrlA;
  logic [7:0] ctrlD;
  logic [7:0] ratio;
  modport regs (output ctrlA, output ctrlD, input ratio);
  modport core (input ctrlA, input ctrlD, output ratio);
endinterface
`default_nettype wire

// file: rtl/rcis_axil_slave.sv
`timescale 1ns/100ps
`default_nettype none
module rcis_axil_slave #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  rcis_reg_if.regs               regs
);
  import rcis_pkg::*;

  typedef struct packed {
    logic              awReady;
    logic              wReady;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arReady;
    logic              rValid;
    logic [1:0]        rResp;
    logic [7:0]        rData;
    logic              awHave;
    logic              wHave;
    logic [ADDR_W-1:0] awAddr;
    logic [7:0]        wData;
    logic              wLane0;
    logic [7:0]        ctrlA;
    logic [7:0]        ctrlD;
  } rcis_axil_t;

  rcis_axil_t s;
  rcis_axil_t next_s;

  // 0 none, 1 control a, 2 control d, 3 ratio readback
  function automatic logic [1:0] regHit(input logic [ADDR_W-1:0] a);
    regHit = 2'h0;
    if (a[1:0] == 2'h0) begin
      if (a[ADDR_W-1:2] == (ADDR_W-2)'(CTRL_A_IDX)) regHit = 2'h1;
      if (a[ADDR_W-1:2] == (ADDR_W-2)'(CTRL_D_IDX)) regHit = 2'h2;
      if (a[ADDR_W-1:2] == (ADDR_W-2)'(RATIO_IDX))  regHit = 2'h3;
    end
  endfunction

  always_comb begin
    next_s = s;
    if (awvalid && s.awReady) begin
      next_s.awHave = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && s.wReady) begin
      next_s.wHave  = 1'b1;
      next_s.wData  = wdata[7:0];
      next_s.wLane0 = wstrb[0];
    end
    if (s.bValid && bready) next_s.bValid = 1'b0;
    if (next_s.awHave && next_s.wHave && !next_s.bValid) begin
      next_s.awHave = 1'b0;
      next_s.wHave  = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp  = RESP_OKAY;
      case (regHit(next_s.awAddr))
        2'h1: if (next_s.wLane0) next_s.ctrlA = next_s.wData;
        2'h2: if (next_s.wLane0) next_s.ctrlD = next_s.wData;
        2'h3: next_s.bResp = RESP_SLVERR;
        default: next_s.bResp = RESP_DECERR;
      endcase
    end
    if (s.rValid && rready) next_s.rValid = 1'b0;
    if (arvalid && s.arReady) begin
      next_s.rValid = 1'b1;
      next_s.rResp  = RESP_OKAY;
      case (regHit(araddr))
        2'h1: next_s.rData = s.ctrlA;
        2'h2: next_s.rData = s.ctrlD;
        2'h3: next_s.rData = regs.ratio;
        default: begin
          next_s.rData = 8'h00;
          next_s.rResp = RESP_DECERR;
        end
      endcase
    end
    next_s.awReady = !next_s.awHave;
    next_s.wReady  = !next_s.wHave;
    next_s.arReady = !next_s.rValid;
    if (!rst_b) begin
      next_s       = '0;
      next_s.ctrlA = CTRL_A_RESET;
      next_s.ctrlD = CTRL_D_RESET;
    end
  end

  always_ff @(posedge sys_clk) begin
    s <= next_s;
  end

  assign awready    = s.awReady;
  assign wready     = s.wReady;
  assign bvalid     = s.bValid;
  assign bresp      = s.bResp;
  assign arready    = s.arReady;
  assign rvalid     = s.rValid;
  assign rresp      = s.rResp;
  assign rdata      = {24'h000000, s.rData};
  assign regs.ctrlA = s.ctrlA;
  assign regs.ctrlD = s.ctrlD;

  sequence bothTaken;
    awvalid && awready && wvalid && wready && !bvalid;
  endsequence

  write_resp_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bothTaken |=> bvalid)
    else $error("write not answered after address and data");

  resp_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (bvalid && !bready) |=> (bvalid && $stable(bresp)))
    else $error("write response dropped before bready");

  read_resp_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (arvalid && arready) |=> (rvalid && !arready))
    else $error("read not answered one cycle after address");

endmodule
`default_nettype wire

// file: rtl/rcis_clock_select.sv
`timescale 1ns/100ps
`default_nettype none
module rcis_clock_select #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [7:0]        positiveLineInputs,
  input  wire logic              negativeLineInput,
  input  wire logic              pllLocked,
  input  wire logic              pllRecoveredClock,
  input  wire logic              externalReferenceClock,
  output logic                   recoveredMasterClock,
  output logic                   recoveredMasterClockOe,
  input  wire logic              outputBitClockIn,
  output logic                   outputBitClockOut,
  output logic                   outputBitClockOe,
  input  wire logic              outputWordClockIn,
  output logic                   outputWordClockOut,
  output logic                   outputWordClockOe,
  output logic                   receiveLine,
  output logic                   passThroughLine,
  output logic                   lowPower
);
  import rcis_pkg::*;

  rcis_reg_if regBus ();

  rcis_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_regs (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .regs    (regBus.regs)
  );

  rcis_core_t s;
  rcis_core_t next_s;

  logic       refTick;
  logic       recTick;
  logic       srcTick;
  logic       master;
  logic       rateHalf;
  logic       winEnd;
  logic [7:0] refNext;

  function automatic logic [SEL_W-1:0] muxSel(
    input logic [7:0]  ctrl,
    input int unsigned lsb
  );
    muxSel = ctrl[lsb +: SEL_W];
  endfunction

  always_comb begin
    refTick  = externalReferenceClock & ~s.refPrev;
    recTick  = pllRecoveredClock & ~s.recPrev;
    srcTick  = s.switched ? refTick : recTick;
    master   = regBus.ctrlD[CD_MASTER_BIT];
    rateHalf = regBus.ctrlA[CA_RATE_BIT];
    winEnd   = recTick && (s.winCnt == RATIO_LAST);
    refNext  = s.refCount;
    if (refTick && (s.refCount != COUNT_MAX)) begin
      refNext = 8'(s.refCount + 8'h01);
    end

    next_s          = s;
    next_s.lowPower = 1'b0;
    next_s.refPrev  = externalReferenceClock;
    next_s.recPrev  = pllRecoveredClock;

    // mux outputs follow the selects in control d
    next_s.rxLine   = positiveLineInputs[muxSel(regBus.ctrlD,
                      CD_RX_SEL_LSB)] & ~negativeLineInput;
    next_s.passLine = positiveLineInputs[muxSel(regBus.ctrlD,
                      CD_PASS_SEL_LSB)];

    // fall back to the reference clock while the pll is out of lock
    next_s.switched = regBus.ctrlA[CA_SWITCH_BIT] & ~pllLocked;
    if (recTick) next_s.divPhase = ~s.divPhase;
    if (s.switched) begin
      next_s.mclk = externalReferenceClock;
    end else if (rateHalf) begin
      next_s.mclk = next_s.divPhase;
    end else begin
      next_s.mclk = pllRecoveredClock;
    end
    next_s.mclkOe = ~regBus.ctrlD[CD_TRISTATE_BIT];

    // ratio of reference edges per 64 recovered edges
    if (recTick) next_s.winCnt = RATIO_WIN_W'(s.winCnt + 6'h01);
    if (winEnd) begin
      next_s.ratio    = refNext;
      next_s.refCount = 8'h00;
    end else begin
      next_s.refCount = refNext;
    end

    if (master) begin
      next_s.bitOe  = 1'b1;
      next_s.wordOe = 1'b1;
      if (srcTick) begin
        next_s.bitCnt  = ~s.bitCnt;
        next_s.wordCnt = WORD_CNT_W'(s.wordCnt + 7'h01);
        if (s.bitCnt == BIT_LAST) next_s.bitClk = ~s.bitClk;
        if (s.wordCnt == WORD_LAST) next_s.wordClk = ~s.wordClk;
      end
    end else begin
      // slave: release the pins and lock the framing to the partner
      next_s.bitOe  = 1'b0;
      next_s.wordOe = 1'b0;
      next_s.bitClk = outputBitClockIn;
      if (outputWordClockIn != s.wordClk) begin
        next_s.wordClk = outputWordClockIn;
        next_s.wordCnt = '0;
        next_s.bitCnt  = 1'b0;
      end
    end

    if (!rst_b) next_s = CORE_RESET;
  end

  always_ff @(posedge sys_clk) begin
    s <= next_s;
  end

  assign regBus.ratio           = s.ratio;
  assign recoveredMasterClock   = s.mclk;
  assign recoveredMasterClockOe = s.mclkOe;
  assign outputBitClockOut      = s.bitClk;
  assign outputBitClockOe       = s.bitOe;
  assign outputWordClockOut     = s.wordClk;
  assign outputWordClockOe      = s.wordOe;
  assign receiveLine            = s.rxLine;
  assign passThroughLine        = s.passLine;
  assign lowPower               = s.lowPower;

  reset_quiet_a: assert property (@(posedge sys_clk)
    !rst_b |=> (lowPower && !recoveredMasterClockOe && !outputBitClockOe
                && !outputWordClockOe && !receiveLine && s.ratio == 8'h00))
    else $error("state not cleared during reset");

  mux_select_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    1'b1 |=> (receiveLine == ($past(positiveLineInputs[muxSel(
      regBus.ctrlD, CD_RX_SEL_LSB)]) & !$past(negativeLineInput))))
    else $error("receive line does not follow selected input");

  clock_switch_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    (regBus.ctrlA[CA_SWITCH_BIT] && !pllLocked) ##1 s.switched
      |=> (recoveredMasterClock == $past(externalReferenceClock)))
    else $error("reference clock not switched onto master clock");

  ratio_load_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    winEnd |=> (s.ratio == $past(refNext) && s.refCount == 8'h00))
    else $error("clock ratio not loaded at window end");

  rate_full_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!s.switched && !rateHalf)
      |=> (recoveredMasterClock == $past(pllRecoveredClock)))
    else $error("master clock not at full rate");

  rate_half_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!s.switched && rateHalf && recTick)
      |=> (recoveredMasterClock == !$past(s.divPhase)))
    else $error("master clock not halved");

  tristate_pin_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    regBus.ctrlD[CD_TRISTATE_BIT] |=> !recoveredMasterClockOe)
    else $error("master clock pin driven while tri-stated");

  word_toggle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (master && srcTick && s.wordCnt == WORD_LAST)
      |=> (outputWordClockOut != $past(outputWordClockOut)))
    else $error("word clock missed its half period");

  word_steady_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (master && !(srcTick && s.wordCnt == WORD_LAST))
      |=> $stable(outputWordClockOut))
    else $error("word clock toggled early");

  slave_release_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    !master |=> (!outputBitClockOe && !outputWordClockOe))
    else $error("serial clocks driven in slave mode");

endmodule
`default_nettype wire

// file: verif/rcis_partner.sv
`timescale 1ns/100ps
`default_nettype none
// audio source side: recovered and reference clocks, lock flag, and the
// downstream processor that clocks the serial port while the block is slave
module rcis_partner #(
  parameter int REC_HALF = 2,
  parameter int REF_HALF = 3
) (
  input  wire logic sys_clk,
  input  wire logic lockReq,
  input  wire logic outputBitClockOe,
  input  wire logic outputWordClockOe,
  output logic      pllLocked,
  output logic      pllRecoveredClock,
  output logic      externalReferenceClock,
  output logic      bitDrive,
  output logic      wordDrive,
  output logic      slaveOe
);
  int recCnt = 0;
  int refCnt = 0;
  logic [7:0] slvCnt = '0;
  logic recClk = 1'h0;
  logic refClk = 1'h0;
  assign pllLocked = lockReq;
  assign pllRecoveredClock = recClk;
  assign externalReferenceClock = refClk;
  // clocks run from time zero so they are settled before reset lifts
  always @(posedge sys_clk) begin
    recCnt <= (recCnt + 1) % REC_HALF;
    refCnt <= (refCnt + 1) % REF_HALF;
    if (recCnt == REC_HALF - 1) recClk <= ~recClk;
    if (refCnt == REF_HALF - 1) refClk <= ~refClk;
    slvCnt <= slvCnt + 8'h01;
  end
  // drive serial clocks only while the block is not master
  assign slaveOe = ~(outputBitClockOe | outputWordClockOe);
  assign bitDrive = slvCnt[1];
  assign wordDrive = slvCnt[7];
endmodule
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rcis_pkg::*;
  localparam int REC_HALF = 2;
  localparam int REF_HALF = 3;
  localparam logic [7:0] CA_T [6] = '{8'h00, 8'h02, 8'h80,
                                      8'h82, 8'h00, 8'h80};
  localparam logic LK_T [6] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1};
  localparam int PER_T [6] = '{4, 8, 6, 6, 4, 4};
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] awaddr = '0, araddr = '0, positiveLineInputs = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, negativeLineInput = 1'h0;
  logic lockReq = 1'h1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic pllLocked, pllRecoveredClock, externalReferenceClock;
  logic recoveredMasterClock, recoveredMasterClockOe;
  logic outputBitClockIn, outputBitClockOut, outputBitClockOe;
  logic outputWordClockIn, outputWordClockOut, outputWordClockOe;
  logic receiveLine, passThroughLine, lowPower, bitDrive, wordDrive, slaveOe;
  logic [31:0] seed = 32'h00000055;
  int fails = 0;
  int checkCount = 0;
  int cM, cR, cW, cB;

  rcis_clock_select dut (.*);
  rcis_partner #(.REC_HALF(REC_HALF), .REF_HALF(REF_HALF)) partner (.*);
  assign outputBitClockIn = slaveOe ? bitDrive : outputBitClockOut;
  assign outputWordClockIn = slaveOe ? wordDrive : outputWordClockOut;

  always #2 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_near(input int got, input int exp);
    checkCount++;
    if (got > exp + 1 || got < exp - 1) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [7:0] w,
                     input logic [1:0] er);
    logic done;
    done = 1'h0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h000000, w};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // the wait ends when bvalid is taken; a missing response is caught only by the watchdog
    while (!done) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        chk(bresp, er);
        bready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] q,
                     input logic [1:0] er);
    logic done;
    done = 1'h0;
    q = '0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        q = rdata;
        chk(rresp, er);
        rready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [7:0] w,
                       input logic [1:0] eb, input logic [1:0] er,
                       input logic [31:0] exp);
    axw(a, w, eb);
    axr(a, d, er);
    chk(d, exp);
  endtask

  task automatic count_rises(input int n);
    logic pm, pr, pw, pb;
    {cM, cR, cW, cB} = '0;
    {pm, pr, pw, pb} = {recoveredMasterClock, pllRecoveredClock,
                        outputWordClockOut, outputBitClockOut};
    repeat (n) begin
      @(posedge sys_clk);
      cM += int'(recoveredMasterClock & ~pm);
      cR += int'(pllRecoveredClock & ~pr);
      cW += int'(outputWordClockOut & ~pw);
      cB += int'(outputBitClockOut & ~pb);
      {pm, pr, pw, pb} = {recoveredMasterClock, pllRecoveredClock,
                          outputWordClockOut, outputBitClockOut};
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    fails++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    chk(lowPower, 1'h1);
    rst_b <= 1'h1;
    repeat (2) @(posedge sys_clk);
    chk(lowPower, 1'h0);
    chk(recoveredMasterClockOe, 1'h1);
    chk(outputWordClockOe, 1'h0);
    axr(8'h10, d, RESP_OKAY);
    chk(d, {24'h000000, CTRL_D_RESET});
    wr_rd(8'h60, 8'h5A, RESP_SLVERR, RESP_OKAY, 32'h00000000);
    wr_rd(8'h04, 8'hA5, RESP_OKAY, RESP_OKAY, 32'h000000A5);
    wr_rd(8'h08, 8'h11, RESP_DECERR, RESP_DECERR, 32'h00000000);
    wr_rd(8'h11, 8'h22, RESP_DECERR, RESP_DECERR, 32'h00000000);
    for (int s = 0; s < 8; s++) begin
      axw(8'h10, 8'((s << 3) | (7 - s)), RESP_OKAY);
      repeat (4) begin
        @(posedge sys_clk);
        positiveLineInputs <= 8'(xs() >> 3);
        negativeLineInput <= 1'(xs() >> 9);
        repeat (3) @(posedge sys_clk);
        chk(receiveLine, positiveLineInputs[s] & ~negativeLineInput);
        chk(passThroughLine, positiveLineInputs[7 - s]);
      end
    end
    for (int i = 0; i < 6; i++) begin
      axw(8'h04, CA_T[i], RESP_OKAY);
      lockReq <= LK_T[i];
      repeat (8) @(posedge sys_clk);
      count_rises(600);
      chk_near(cM, 600 / PER_T[i]);
    end
    axr(8'h60, d, RESP_OKAY);
    chk_near(int'(d), 64 * REC_HALF / REF_HALF);
    axw(8'h10, 8'h80, RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk(recoveredMasterClockOe, 1'h0);
    axw(8'h10, 8'h40, RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk(recoveredMasterClockOe, 1'h1);
    chk(outputWordClockOe, 1'h1);
    chk(outputBitClockOe, 1'h1);
    count_rises(4096);
    chk_near(cW, 4096 / (2 * REC_HALF) / 256);
    chk_near(cB, 4096 / (2 * REC_HALF) / 4);
    rst_b <= 1'h0;
    repeat (2) @(posedge sys_clk);
    chk(lowPower, 1'h1);
    chk(recoveredMasterClockOe, 1'h0);
    chk(outputWordClockOe, 1'h0);
    rst_b <= 1'h1;
    repeat (2) @(posedge sys_clk);
    axr(8'h10, d, RESP_OKAY);
    chk(d, 32'h00000000);
    stop_test();
  end
endmodule
`default_nettype wire
